// ==== core/asr_pkg.sv ====
// Purpose: Shared constants and carrier types for the static memory bus controller
// Assumes: core clock of 25 MHz; times are in nanoseconds
// Notes: Cycle counts are derived from the printed times and the clock period
`default_nettype none

package asr_pkg;

    // ------------------------------------------------------------
    // Clock and bus geometry
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int LANE_W = 2;

    // ------------------------------------------------------------
    // Timing figures as printed, in ns
    // ------------------------------------------------------------
    localparam int ADDRESS_ACCESS_TIME_NS = 45;
    localparam int OUTPUT_HOLD_AFTER_ADDRESS_NS = 10;
    localparam int OUTPUT_ENABLE_ACCESS_TIME_NS = 22;
    localparam int LANE_ENABLE_ACCESS_TIME_NS = 45;
    localparam int READ_CYCLE_NS = 45;
    localparam int ADDRESS_SETUP_TO_WRITE_END_NS = 35;
    localparam int ADDRESS_SETUP_TO_WRITE_START_NS = 0;
    localparam int ADDRESS_HOLD_AFTER_WRITE_NS = 0;
    localparam int WRITE_DATA_SETUP_NS = 25;
    localparam int WRITE_DATA_HOLD_NS = 0;
    localparam int WRITE_STROBE_RELEASE_TIME_NS = 18;
    localparam int WRITE_PULSE_NS = 35;
    localparam int WRITE_CYCLE_NS = 45;
    localparam int DESELECT_TO_RETENTION_TIME_NS = 0;

    // ------------------------------------------------------------
    // Least times rounded up to whole cycles, never below one
    // ------------------------------------------------------------
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int READ_WAIT_CYC = cyc_up(ADDRESS_ACCESS_TIME_NS);
    localparam int OE_WAIT_CYC = cyc_up(OUTPUT_ENABLE_ACCESS_TIME_NS);
    localparam int LANE_WAIT_CYC = cyc_up(LANE_ENABLE_ACCESS_TIME_NS);
    localparam int READ_CYC = cyc_up(READ_CYCLE_NS);
    localparam int PULSE_CYC = cyc_up(WRITE_PULSE_NS);
    localparam int OE_PULSE_CYC =
        cyc_up(WRITE_STROBE_RELEASE_TIME_NS + WRITE_DATA_SETUP_NS);
    localparam int SETUP_CYC = cyc_up(WRITE_DATA_SETUP_NS);
    localparam int WRITE_CYC = cyc_up(WRITE_CYCLE_NS);
    localparam int RET_CYC = cyc_up(DESELECT_TO_RETENTION_TIME_NS);
    localparam int CNT_W = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [LANE_W-1:0] lanes;
        logic write;
    } asr_req_t;

    typedef struct packed {
        logic select_active_low_n;
        logic select_active_high;
        logic write_strobe_n;
        logic output_enable_n;
        logic upper_lane_enable_n;
        logic lower_lane_enable_n;
    } asr_ctl_t;

    localparam asr_ctl_t CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

`default_nettype wire

// ==== core/asr_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for a pin bus
// Assumes: inputs arrive from outside the core clock domain
// Notes: A change is taken once the second and third stages agree
`default_nettype none

module asr_sync #(
    parameter int W = 16
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ------------------------------------------------------------
    // Agreement filter, per bit
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    pin_out[i] <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    pin_out[i] <= s3_q[i];
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

// ==== core/asr_ctrl.sv ====
// Purpose: Controller that drives an asynchronous 16-bit static memory through its pins
// Assumes: one core clock; requests come from logic on the same clock
// Notes: Reads sample the data lines after access time plus synchroniser latency
`default_nettype none

// Notes on behaviour
// - Write only while strobe, selects, lane overlap
// - Write data valid 25 ns before end
// - Deselect by selects or both lanes off
// - Write strobe stays high during reads
// - Address valid no later than select
// - Address stable 35 ns before write end
// - Address may settle at write start
// - Address may change at write end
// - Strobe pulse at least 18 plus 25 ns
// - Deselect before retention, no delay needed
// - Do not drive while device drives
module asr_ctrl #(
    parameter int SYNC_LAT = 3
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire asr_pkg::asr_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    output logic [asr_pkg::DATA_W-1:0] rd_data,
    output logic rd_valid,
    input wire logic retention_req,
    output logic retention_ok,
    output logic [asr_pkg::ADDR_W-1:0] mem_addr,
    output asr_pkg::asr_ctl_t mem_ctl,
    input wire logic [asr_pkg::DATA_W-1:0] mem_data_in,
    output logic [asr_pkg::DATA_W-1:0] mem_data_out,
    output logic mem_data_oe
);
    import asr_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_SETUP,
        ST_RD_WAIT,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_RECOVER,
        ST_RETAIN
    } asr_state_t;

    // Sync stages plus the agreement register each add one cycle
    localparam logic [CNT_W-1:0] RD_WAIT_N =
        CNT_W'(READ_WAIT_CYC + SYNC_LAT + 1);
    // Strobe low long enough for both minimum pulse figures
    localparam logic [CNT_W-1:0] WR_PULSE_N =
        CNT_W'((PULSE_CYC > OE_PULSE_CYC) ? PULSE_CYC : OE_PULSE_CYC);
    localparam logic [CNT_W-1:0] WR_REC_N = CNT_W'(WRITE_CYC - PULSE_CYC);

    asr_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    asr_req_t cur_q;
    logic [DATA_W-1:0] din_sync;
    logic [LANE_W-1:0] lane_sel;

    // Lanes of zero would deselect the part; treat as full word
    function automatic logic [LANE_W-1:0] lanes_of(input logic [LANE_W-1:0] l);
        return (l == '0) ? 2'h3 : l;
    endfunction

    asr_sync #(
        .W(DATA_W)
    ) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .pin_in(mem_data_in),
        .pin_out(din_sync)
    );

    assign req_ready = (state_q == ST_IDLE) && !retention_req;
    assign lane_sel = lanes_of(cur_q.lanes);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (retention_req) begin
                        state_q <= ST_RETAIN;
                    end else if (req_valid) begin
                        state_q <= req.write ? ST_WR_SETUP : ST_RD_SETUP;
                    end
                end
                ST_RD_SETUP: begin
                    // Address settled one cycle before select goes active
                    state_q <= ST_RD_WAIT;
                    cnt_q <= RD_WAIT_N;
                end
                ST_RD_WAIT: begin
                    // Wait covers access time plus input synchroniser
                    if (cnt_q <= 4'h1) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                ST_WR_SETUP: begin
                    state_q <= ST_WR_PULSE;
                    cnt_q <= WR_PULSE_N;
                end
                ST_WR_PULSE: begin
                    if (cnt_q <= 4'h1) begin
                        state_q <= ST_WR_RECOVER;
                        cnt_q <= WR_REC_N;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                ST_WR_RECOVER: begin
                    if (cnt_q <= 4'h1) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                ST_RETAIN: begin
                    if (!retention_req) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Request capture; address and data stay put past write end
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cur_q <= '0;
        end else if (req_ready && req_valid) begin
            cur_q <= req;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mem_ctl <= CTL_IDLE;
            mem_addr <= '0;
            mem_data_out <= '0;
            mem_data_oe <= 1'b0;
        end else begin
            mem_ctl <= CTL_IDLE;
            mem_data_oe <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (req_ready && req_valid) begin
                        mem_addr <= req.addr;
                        mem_data_out <= req.wdata;
                    end
                end
                ST_RD_SETUP, ST_RD_WAIT: begin
                    // Strobe held high for the whole read
                    mem_ctl.select_active_low_n <= 1'b0;
                    mem_ctl.select_active_high <= 1'b1;
                    mem_ctl.write_strobe_n <= 1'b1;
                    mem_ctl.output_enable_n <= 1'b0;
                    mem_ctl.upper_lane_enable_n <= !lane_sel[1];
                    mem_ctl.lower_lane_enable_n <= !lane_sel[0];
                end
                ST_WR_SETUP, ST_WR_PULSE: begin
                    // Output enable kept high so the part never drives; pulse
                    // of two cycles covers both minimum pulse figures
                    mem_ctl.select_active_low_n <= 1'b0;
                    mem_ctl.select_active_high <= 1'b1;
                    mem_ctl.output_enable_n <= 1'b1;
                    mem_ctl.upper_lane_enable_n <= !lane_sel[1];
                    mem_ctl.lower_lane_enable_n <= !lane_sel[0];
                    // Low for every cycle of the pulse count
                    mem_ctl.write_strobe_n <= (state_q == ST_WR_SETUP);
                    mem_data_oe <= 1'b1;
                end
                ST_WR_RECOVER: begin
                    // Data still driven one cycle past strobe rise
                    mem_data_oe <= (cnt_q == WR_REC_N);
                end
                default: begin
                    mem_ctl <= CTL_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read return; sampled late so old data hold does not matter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_data <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= (state_q == ST_RD_WAIT) && (cnt_q <= 4'h1);
            if ((state_q == ST_RD_WAIT) && (cnt_q <= 4'h1)) begin
                rd_data <= din_sync;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            retention_ok <= 1'b0;
        end else begin
            retention_ok <= (state_q == ST_RETAIN);
        end
    end
endmodule

`default_nettype wire

// ==== tb/asr_ctrl_chk.sv ====
// Purpose: Pin timing assertions for the static memory controller
// Assumes: all pins registered on core_clk
// Notes: Bound to the controller from the bench top
`default_nettype none
module asr_ctrl_chk
    import asr_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire asr_pkg::asr_req_t req,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rd_valid,
    input wire logic retention_ok,
    input wire logic [asr_pkg::ADDR_W-1:0] mem_addr,
    input wire asr_pkg::asr_ctl_t mem_ctl,
    input wire logic [asr_pkg::DATA_W-1:0] mem_data_out,
    input wire logic mem_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sel, lane_on, rd_take, ws_n;
    assign sel = !mem_ctl.select_active_low_n && mem_ctl.select_active_high;
    assign lane_on = !(mem_ctl.upper_lane_enable_n && mem_ctl.lower_lane_enable_n);
    assign rd_take = req_valid && req_ready && !req.write;
    assign ws_n = mem_ctl.write_strobe_n;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // Pin relations
    // ----------------------------------------
    AST_WR_OVERLAP: assert property (!ws_n |-> sel && lane_on)
        else $error("strobe low without select and lane");
    AST_RD_NO_STROBE: assert property (!mem_ctl.output_enable_n |-> ws_n)
        else $error("strobe low while output enabled");
    AST_NO_FIGHT: assert property (mem_data_oe |-> mem_ctl.output_enable_n)
        else $error("data driven while device may drive");
    AST_PULSE_LEN: assert property ($fell(ws_n) |-> !ws_n [*2])
        else $error("strobe pulse too short");
    AST_DATA_HOLD: assert property ($rose(ws_n) |-> mem_data_oe && $stable(mem_data_out))
        else $error("write data not held to strobe end");
    AST_ADDR_WR: assert property (!ws_n |-> $stable(mem_addr))
        else $error("address moved during write");
    AST_ADDR_FIRST: assert property ($fell(mem_ctl.select_active_low_n) |-> $stable(mem_addr))
        else $error("address changed with select");
    AST_RD_LAT: assert property (rd_take |=> !rd_valid [*3] ##[1:10] rd_valid)
        else $error("read answer out of window");
    AST_RET_QUIET: assert property (retention_ok |-> !(sel && lane_on))
        else $error("selected while in retention");
    cover property (rd_take);
    cover property ($fell(ws_n));
    cover property ($rose(retention_ok));
endmodule
`default_nettype wire

// ==== tb/asr_mem_model.sv ====
// Purpose: Behavioural static memory on the far side of the controller
// Assumes: controller pins change only after core_clk edges
// Notes: Undriven lanes show a pattern that changes every cycle
`default_nettype none
module asr_mem_model
    import asr_pkg::*;
(
    input wire logic core_clk,
    input wire logic [asr_pkg::ADDR_W-1:0] mem_addr,
    input wire asr_pkg::asr_ctl_t mem_ctl,
    input wire logic [asr_pkg::DATA_W-1:0] mem_data_out,
    input wire logic mem_data_oe,
    output logic [asr_pkg::DATA_W-1:0] mem_data_in,
    output var int err_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] pat = 16'h5A5A;
    logic [DATA_W-1:0] rd_word, dly_word, wd;
    logic [ADDR_W-1:0] wa;
    logic [1:0] ln_n, lane_d, wl, byte_on;
    logic sel, wr_act, drv, drv_d, upd = 1'b0, armed = 1'b0;
    realtime t_addr = 0.0, t_data = 0.0;
    initial err_cnt = 0;
    always @(posedge core_clk) pat <= ~pat ^ 16'h0001;
    assign ln_n = {mem_ctl.upper_lane_enable_n, mem_ctl.lower_lane_enable_n};
    assign sel = !mem_ctl.select_active_low_n && mem_ctl.select_active_high;
    assign wr_act = sel && !mem_ctl.write_strobe_n && !(&ln_n);
    assign drv = sel && !mem_ctl.output_enable_n && mem_ctl.write_strobe_n && !(&ln_n);
    always @(mem_addr or upd) rd_word = mem.exists(int'(mem_addr)) ? mem[int'(mem_addr)] : 16'h0000;
    // Inertial delays: old word stays until the access time has run out
    assign #(ADDRESS_ACCESS_TIME_NS) dly_word = rd_word;
    assign #(OUTPUT_ENABLE_ACCESS_TIME_NS) drv_d = drv;
    assign #(LANE_ENABLE_ACCESS_TIME_NS) lane_d = ~ln_n;
    // Release is immediate, driving waits for the delays, so no overlap
    assign byte_on = {2{drv && drv_d}} & ~ln_n & lane_d;
    assign mem_data_in = mem_data_oe ? mem_data_out :
        ({{8{byte_on[1]}}, {8{byte_on[0]}}} & dly_word) |
        ({{8{!byte_on[1]}}, {8{!byte_on[0]}}} & pat);
    always @(mem_addr) t_addr = $realtime;
    always @(mem_data_out) t_data = $realtime;
    always @(posedge wr_act) armed = 1'b1;
    always @* if (wr_act) begin
        wa = mem_addr;
        wd = mem_data_out;
        wl = ~ln_n;
    end
    always @(negedge wr_act) if (armed) begin
        if ($realtime - t_data < WRITE_DATA_SETUP_NS) err_cnt++;
        if ($realtime - t_addr < ADDRESS_SETUP_TO_WRITE_END_NS) err_cnt++;
        if (!mem.exists(int'(wa))) mem[int'(wa)] = 16'h0000;
        if (wl[0]) mem[int'(wa)][7:0] = wd[7:0];
        if (wl[1]) mem[int'(wa)][15:8] = wd[15:8];
        upd = ~upd;
    end
    always @(posedge core_clk) if (mem_data_oe && drv) err_cnt++;
endmodule
`default_nettype wire

// ==== tb/async_sram_bus_timing_tb.sv ====
// Purpose: Self-checking bench for the static memory controller
// Assumes: behavioural memory model on the pins
// Notes: Random traffic over a small address pool plus corner cases
`default_nettype none
module async_sram_bus_timing_tb import asr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, reset, req_valid, req_ready, rd_valid, retention_req, retention_ok, mem_data_oe;
    asr_req_t req;
    asr_ctl_t mem_ctl;
    logic [DATA_W-1:0] rd_data, mem_data_in, mem_data_out;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] ref_mem [int];
    int model_errs, num_errors = 0, checks = 0;
    asr_ctrl uut (.core_clk(core_clk), .reset(reset), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .retention_req(retention_req), .retention_ok(retention_ok), .mem_addr(mem_addr),
        .mem_ctl(mem_ctl), .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
        .mem_data_oe(mem_data_oe));
    asr_mem_model dev (.core_clk(core_clk), .mem_addr(mem_addr), .mem_ctl(mem_ctl),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in),
        .err_cnt(model_errs));
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic [DATA_W-1:0] lane_mask(input logic [LANE_W-1:0] ln);
        return (ln == 2'b00) ? 16'hFFFF : {{8{ln[1]}}, {8{ln[0]}}};
    endfunction
    // Called and returns at a falling edge; valid stays low for a cycle between requests
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic [LANE_W-1:0] ln);
        logic [DATA_W-1:0] m;
        int n;
        m = lane_mask(ln);
        n = 0;
        @(negedge core_clk);
        req = '{addr: a, wdata: d, lanes: ln, write: wr};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        req_valid = 1'b0;
        if (!ref_mem.exists(int'(a))) ref_mem[int'(a)] = 16'h0000;
        if (wr) ref_mem[int'(a)] = (ref_mem[int'(a)] & ~m) | (d & m);
        else begin
            while (rd_valid !== 1'b1 && n < 40) begin
                @(negedge core_clk);
                n++;
            end
            check(rd_data & m, ref_mem[int'(a)] & m);
        end
        if (n >= 40) begin
            num_errors++;
            print_verdict();
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        int n;
        logic [ADDR_W-1:0] pool [4];
        void'($urandom(25));
        reset = 1'b1;
        req = '0;
        req_valid = 1'b0;
        retention_req = 1'b0;
        pool = '{19'h00000, 19'h7FFFF, 19'h2AAAA, 19'h55555};
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        // Corner cases: full word, single lanes, lanes 0 meaning both
        access(1'b1, 19'h7FFFF, 16'hA55A, 2'b11);
        access(1'b1, 19'h7FFFF, 16'h3C00, 2'b10);
        access(1'b1, 19'h00000, 16'h00C3, 2'b01);
        access(1'b0, 19'h7FFFF, 16'h0000, 2'b00);
        access(1'b0, 19'h00000, 16'h0000, 2'b01);
        for (int i = 0; i < 40; i++) begin
            access(1'($urandom_range(1)), pool[$urandom_range(3)], 16'($urandom), 2'($urandom));
        end
        retention_req = 1'b1;
        n = 0;
        while (retention_ok !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        check({15'h0000, req_ready}, 16'h0000);
        check({15'h0000, mem_ctl.select_active_low_n || !mem_ctl.select_active_high ||
            (mem_ctl.upper_lane_enable_n && mem_ctl.lower_lane_enable_n)}, 16'h0001);
        retention_req = 1'b0;
        if (n >= 40) num_errors++;
        access(1'b0, 19'h7FFFF, 16'h0000, 2'b00);
        check(16'(model_errs), 16'h0000);
        print_verdict();
    end
endmodule
bind asr_ctrl asr_ctrl_chk chk (.core_clk(core_clk), .reset(reset), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rd_valid(rd_valid),
    .retention_ok(retention_ok), .mem_addr(mem_addr), .mem_ctl(mem_ctl),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
`default_nettype wire
